/* hw/flash_ctrl_pkg.sv */
package flash_ctrl_pkg;

	// ------------------------------------------------------------
	// register byte offsets on the axi4-lite slave
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_STATUS = 8'h00; // flash_status_reg
	localparam logic [7:0] OFS_SLOT_INDEX = 8'h04; // command_slot_index
	localparam logic [7:0] OFS_COMMAND_OBJECT = 8'h08; // command_object, slot picked by index
	localparam logic [7:0] OFS_DIVIDER = 8'h0c; // flash_clock_divider_code
	localparam logic [7:0] OFS_ECC_INDEX = 8'h10; // ecc_index_reg
	localparam logic [7:0] OFS_ECC_RESULT = 8'h14; // ecc_error_result_reg
	localparam logic [7:0] OFS_ECC_FLAGS = 8'h18; // ecc fault flags, write one to clear
	localparam logic [7:0] OFS_RESERVED_TEST = 8'h1c; // reserved_factory_test
	localparam logic [7:0] OFS_PROTECT = 8'h20; // protection of the one-time field

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int STAT_DONE_BIT = 7; // command_complete_flag
	localparam int STAT_ACCESS_BIT = 5; // access_error_flag
	localparam int STAT_PROTECT_BIT = 4; // protection_violation_flag
	localparam int STAT_VERIFY_HI_BIT = 1; // verify_error_status_hi
	localparam int STAT_VERIFY_LO_BIT = 0; // verify_fatal_status_lo
	localparam int DIV_LOADED_BIT = 7; // divider has been written with a legal code
	localparam int ECC_DOUBLE_BIT = 1;
	localparam int ECC_SINGLE_BIT = 0;

	// ------------------------------------------------------------
	// command and slot encodings
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_PROGRAM_ONCE = 8'h07;
	localparam logic [2:0] SLOT_CMD = 3'h0;
	localparam logic [2:0] SLOT_PHRASE = 3'h1;
	localparam logic [2:0] SLOT_WORD0 = 3'h2;
	localparam logic [2:0] SLOT_LAST = 3'h5;
	localparam logic [15:0] PHRASE_INDEX_MAX = 16'h0007;
	localparam int OTP_BYTES = 64;
	localparam int OTP_PHRASES = 8;
	localparam logic [22:0] OTP_BASE_ADDR = 23'h7f_ff00; // global address of the one-time field
	localparam logic [63:0] ERASED_PHRASE = 64'hffff_ffff_ffff_ffff;
	localparam logic [15:0] INVALID_READ_DATA = 16'hffff;

	// ------------------------------------------------------------
	// reset values and divider range
	// ------------------------------------------------------------
	localparam logic [6:0] DIV_CODE_MIN = 7'h01;
	localparam logic [6:0] DIV_CODE_MAX = 7'h2f;
	localparam logic [6:0] DIV_RESET = 7'h00;
	localparam logic [2:0] ECC_IX_ADDR_HI = 3'h0;
	localparam logic [2:0] ECC_IX_ADDR_LO = 3'h1;
	localparam logic [2:0] ECC_IX_DATA = 3'h2;

	// ------------------------------------------------------------
	// timing: programming pulse measured in flash clock ticks
	// ------------------------------------------------------------
	localparam int PROG_TIME_US = 20;
	localparam int FLASH_OPERATING_CLOCK_NOMINAL_MHZ = 1;
	localparam logic [7:0] PROG_FLASH_OPERATING_CLOCK_TICKS = 8'(PROG_TIME_US * FLASH_OPERATING_CLOCK_NOMINAL_MHZ);

	// ------------------------------------------------------------
	// bus answers
	// ------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic done;
		logic access_err;
		logic prot_viol;
		logic verify_err;
		logic verify_fatal;
	} status_t;

	typedef struct packed {
		logic [22:0] addr;
		logic [15:0] data;
	} ecc_fault_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ERASE_READ,
		ST_ERASE_CHECK,
		ST_PROGRAM,
		ST_VERIFY_READ,
		ST_VERIFY_CHECK
	} seq_state_t;

endpackage

/* hw/flash_otp_ctrl.sv */
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps

// Notes on behaviour
// - only the 64-byte, 8-phrase field is programmed
// - phrase index 0 to 7 accepted
// - erase check, then program, then read-back verify
// - done flag low until operation finishes
// - already programmed phrase is refused
// - block 0 reads invalid while busy
// - access error unless slot index is 5
// - access error for unavailable command
// - access error for invalid global address
// - access error for misaligned phrase address
// - protection error for protected address
// - verify high bit on any mismatch
// - verify low bit on uncorrectable mismatch
// - no new ecc capture until flag cleared
// - double fault recorded over single fault
// - ecc result field chosen by index
// - test register reads zero, ignores writes
// - divider code 0x01-0x2f picks flash clock
module flash_otp_ctrl
	import flash_ctrl_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ecc_single_fault,
	input wire logic ecc_double_fault,
	input wire ecc_fault_t ecc_fault_info,
	input wire logic [15:0] block0_array_data,
	output logic [15:0] block0_read_data,
	output logic flash_operating_clock,
	output logic busy
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	status_t status; // flash_status_reg bits
	logic [2:0] command_slot_index; // slot pointer
	logic [15:0] command_object [6]; // parameter slots
	logic [6:0] flash_clock_divider_code; // divider code
	logic div_loaded; // legal code has been written
	logic [6:0] flash_clock_divider_code_cnt; // oscillator cycle counter
	logic [2:0] ecc_result_index; // ecc_index_reg
	logic ecc_single_flag; // single fault recorded
	logic ecc_double_flag; // double fault recorded
	ecc_fault_t ecc_record; // captured fault
	logic protect_otp; // field write protected
	seq_state_t state; // sequencer
	logic [7:0] prog_cnt; // programming pulse ticks left
	logic [2:0] phrase; // latched phrase
	logic [63:0] prog_data; // latched phrase data
	logic [31:0] aw_addr; // held write address
	logic [31:0] w_data; // held write data
	logic [3:0] w_strb; // held strobes
	logic aw_full; // write address held
	logic w_full; // write data held
	logic [63:0] otp_rd_data; // read-back from storage
	logic otp_wr_en; // storage write strobe
	logic next_busy; // sequencer not idle next

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	wire logic aw_hs = s_axi_awvalid & s_axi_awready;
	wire logic w_hs = s_axi_wvalid & s_axi_wready;
	wire logic ar_hs = s_axi_arvalid & s_axi_arready;
	wire logic [31:0] wr_addr = aw_hs ? s_axi_awaddr : aw_addr;
	wire logic [31:0] wr_data = w_hs ? s_axi_wdata : w_data;
	wire logic [3:0] wr_strb = w_hs ? s_axi_wstrb : w_strb;
	wire logic wr_fire = (aw_full | aw_hs) & (w_full | w_hs) & ~s_axi_bvalid;
	wire logic wr_hi = (wr_addr[31:8] == 24'h00_0000);
	wire logic [7:0] wofs = wr_addr[7:0];
	wire logic [7:0] rofs = s_axi_araddr[7:0];
	wire logic rd_hi = (s_axi_araddr[31:8] == 24'h00_0000);
	wire logic lane0 = wr_fire & wr_strb[0];
	wire logic lane1 = wr_fire & wr_strb[1];
	wire logic w_status = lane0 & wr_hi & (wofs == OFS_STATUS);
	wire logic w_index = lane0 & wr_hi & (wofs == OFS_SLOT_INDEX);
	wire logic w_object = wr_fire & wr_hi & (wofs == OFS_COMMAND_OBJECT);
	wire logic w_divider = lane0 & wr_hi & (wofs == OFS_DIVIDER);
	wire logic w_ecc_index = lane0 & wr_hi & (wofs == OFS_ECC_INDEX);
	wire logic w_ecc_flags = lane0 & wr_hi & (wofs == OFS_ECC_FLAGS);
	wire logic w_protect = lane0 & wr_hi & (wofs == OFS_PROTECT);
	// writes to the test register are accepted and dropped
	wire logic wr_mapped = wr_hi & (wofs == OFS_STATUS || wofs == OFS_SLOT_INDEX || wofs == OFS_COMMAND_OBJECT ||
		wofs == OFS_DIVIDER || wofs == OFS_ECC_INDEX || wofs == OFS_ECC_RESULT || wofs == OFS_ECC_FLAGS ||
		wofs == OFS_RESERVED_TEST || wofs == OFS_PROTECT);

	// ------------------------------------------------------------
	// launch checks
	// ------------------------------------------------------------
	// the one-time field is addressed by phrase, so the global address is
	// built from the index and checked like any other programming address
	wire logic [15:0] phrase_arg = command_object[SLOT_PHRASE];
	wire logic [22:0] global_addr = OTP_BASE_ADDR + {phrase_arg[12:0], 3'b000};
	wire logic launch = w_status & wr_data[STAT_DONE_BIT] & status.done & ~busy;
	wire logic bad_slot = (command_slot_index != SLOT_LAST);
	wire logic bad_mode = (command_object[SLOT_CMD][7:0] != CMD_PROGRAM_ONCE) | ~div_loaded;
	wire logic bad_addr = (phrase_arg > PHRASE_INDEX_MAX);
	wire logic misaligned = (global_addr[2:0] != 3'b000);
	wire logic prot_hit = protect_otp & ~bad_addr;
	wire logic launch_err = bad_slot | bad_mode | bad_addr | misaligned;
	// earlier error flags still set also block a launch
	wire logic launch_ok = launch & ~launch_err & ~prot_hit & ~status.access_err & ~status.prot_viol;

	// ------------------------------------------------------------
	// verify comparison
	// ------------------------------------------------------------
	wire logic [63:0] mismatch = otp_rd_data ^ prog_data;
	wire logic any_err = |mismatch;
	wire logic multi_err = |(mismatch & (mismatch - 64'h1)); // more than one bit wrong
	wire logic flash_operating_clock_tick = (flash_clock_divider_code_cnt == flash_clock_divider_code);

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	wire logic [15:0] ecc_view = (ecc_result_index == ECC_IX_ADDR_HI) ? {9'h000, ecc_record.addr[22:16]} :
		(ecc_result_index == ECC_IX_ADDR_LO) ? ecc_record.addr[15:0] :
		(ecc_result_index == ECC_IX_DATA) ? ecc_record.data : 16'h0000;
	wire logic [7:0] status_view = {status.done, 1'b0, status.access_err, status.prot_viol, 2'b00,
		status.verify_err, status.verify_fatal};
	wire logic rd_mapped = rd_hi & (rofs == OFS_STATUS || rofs == OFS_SLOT_INDEX || rofs == OFS_COMMAND_OBJECT ||
		rofs == OFS_DIVIDER || rofs == OFS_ECC_INDEX || rofs == OFS_ECC_RESULT || rofs == OFS_ECC_FLAGS ||
		rofs == OFS_RESERVED_TEST || rofs == OFS_PROTECT);
	wire logic [15:0] slot_view = (command_slot_index > SLOT_LAST) ? 16'h0000 : command_object[command_slot_index];
	wire logic [31:0] rd_value = !rd_hi ? 32'h0000_0000 :
		(rofs == OFS_STATUS) ? {24'h00_0000, status_view} :
		(rofs == OFS_SLOT_INDEX) ? {29'h0000_0000, command_slot_index} :
		(rofs == OFS_COMMAND_OBJECT) ? {16'h0000, slot_view} :
		(rofs == OFS_DIVIDER) ? {24'h00_0000, div_loaded, flash_clock_divider_code} :
		(rofs == OFS_ECC_INDEX) ? {29'h0000_0000, ecc_result_index} :
		(rofs == OFS_ECC_RESULT) ? {16'h0000, ecc_view} :
		(rofs == OFS_ECC_FLAGS) ? {30'h0000_0000, ecc_double_flag, ecc_single_flag} :
		(rofs == OFS_PROTECT) ? {31'h0000_0000, protect_otp} :
		32'h0000_0000; // test register and holes read zero

	assign otp_wr_en = (state == ST_PROGRAM) & flash_operating_clock_tick & (prog_cnt == 8'h01);
	assign next_busy = (state != ST_IDLE) | launch_ok;

	// ------------------------------------------------------------
	// storage for the one-time field
	// ------------------------------------------------------------
	otp_store u_store (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(otp_wr_en),
		.addr(phrase),
		.wr_data(prog_data),
		.rd_data(otp_rd_data)
	);

	// ------------------------------------------------------------
	// axi4-lite write channel
	// ------------------------------------------------------------
	// address and data are held apart so either may come first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= 32'h0000_0000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			if (aw_hs) begin
				aw_addr <= s_axi_awaddr;
				aw_full <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (w_hs) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				w_full <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				// both halves present: answer and free the holders
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
				aw_full <= 1'b0;
				w_full <= 1'b0;
				s_axi_awready <= 1'b0;
				s_axi_wready <= 1'b0;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// axi4-lite read channel
	// ------------------------------------------------------------
	// reads have no side effects, so data is sampled at address time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (ar_hs) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_value;
			s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// parameter slots and configuration
	// ------------------------------------------------------------
	// slots are frozen while a command runs so the latched phrase stays true
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			command_slot_index <= SLOT_CMD;
			for (int i = 0; i <= SLOT_LAST; i++) begin
				command_object[i] <= 16'h0000;
			end
			ecc_result_index <= ECC_IX_ADDR_HI;
			protect_otp <= 1'b0;
		end else begin
			if (w_index & ~busy) begin
				command_slot_index <= wr_data[2:0];
			end
			if (w_object & ~busy & (command_slot_index <= SLOT_LAST)) begin
				if (wr_strb[0]) begin
					command_object[command_slot_index][7:0] <= wr_data[7:0];
				end
				if (wr_strb[1]) begin
					command_object[command_slot_index][15:8] <= wr_data[15:8];
				end
			end
			if (w_ecc_index) begin
				ecc_result_index <= wr_data[2:0];
			end
			if (w_protect & ~busy) begin
				protect_otp <= wr_data[0];
			end
		end
	end

	// ------------------------------------------------------------
	// flash clock divider
	// ------------------------------------------------------------
	// codes outside the legal band are dropped so the flash clock never
	// leaves its window; lane1 is unused here
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flash_clock_divider_code <= DIV_RESET;
			div_loaded <= 1'b0;
			flash_clock_divider_code_cnt <= 7'h00;
			flash_operating_clock <= 1'b0;
		end else begin
			if (w_divider & ~busy & (wr_data[6:0] >= DIV_CODE_MIN) & (wr_data[6:0] <= DIV_CODE_MAX)) begin
				flash_clock_divider_code <= wr_data[6:0];
				div_loaded <= 1'b1;
			end
			flash_clock_divider_code_cnt <= flash_operating_clock_tick ? 7'h00 : flash_clock_divider_code_cnt + 7'h01;
			flash_operating_clock <= flash_operating_clock_tick & div_loaded;
		end
	end

	// ------------------------------------------------------------
	// ecc fault capture
	// ------------------------------------------------------------
	// one record holds either kind, so any set flag locks it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ecc_single_flag <= 1'b0;
			ecc_double_flag <= 1'b0;
			ecc_record <= '0;
		end else begin
			if (~ecc_single_flag & ~ecc_double_flag & (ecc_single_fault | ecc_double_fault)) begin
				ecc_record <= ecc_fault_info;
			end
			// a fault arriving with a clear is lost unless both flags were already clear
			if (~ecc_single_flag & ~ecc_double_flag & ecc_double_fault) begin
				ecc_double_flag <= 1'b1;
			end else if (w_ecc_flags & wr_data[ECC_DOUBLE_BIT]) begin
				ecc_double_flag <= 1'b0;
			end
			if (~ecc_single_flag & ~ecc_double_flag & ecc_single_fault & ~ecc_double_fault) begin
				ecc_single_flag <= 1'b1;
			end else if (w_ecc_flags & wr_data[ECC_SINGLE_BIT]) begin
				ecc_single_flag <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// program-once sequencer
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			status <= '{done: 1'b1, default: 1'b0};
			prog_cnt <= 8'h00;
			phrase <= 3'h0;
			prog_data <= ERASED_PHRASE;
			busy <= 1'b0;
		end else begin
			busy <= next_busy;
			// error flags clear on a one written, but a fresh error wins
			if (w_status & wr_data[STAT_ACCESS_BIT] & ~launch) begin
				status.access_err <= 1'b0;
			end
			if (w_status & wr_data[STAT_PROTECT_BIT] & ~launch) begin
				status.prot_viol <= 1'b0;
			end
			unique case (state)
				ST_IDLE: begin
					if (launch) begin
						status.verify_err <= 1'b0;
						status.verify_fatal <= 1'b0;
						status.access_err <= launch_err | status.access_err;
						status.prot_viol <= (prot_hit & ~launch_err) | status.prot_viol;
					end
					if (launch_ok) begin
						status.done <= 1'b0;
						phrase <= phrase_arg[2:0];
						prog_data <= {command_object[SLOT_WORD0 + 3'h3], command_object[SLOT_WORD0 + 3'h2],
							command_object[SLOT_WORD0 + 3'h1], command_object[SLOT_WORD0]};
						state <= ST_ERASE_READ;
					end
				end
				ST_ERASE_READ: begin
					state <= ST_ERASE_CHECK; // storage read latency
				end
				ST_ERASE_CHECK: begin
					if (otp_rd_data == ERASED_PHRASE) begin
						prog_cnt <= PROG_FLASH_OPERATING_CLOCK_TICKS;
						state <= ST_PROGRAM;
					end else begin
						status.access_err <= 1'b1;
						status.done <= 1'b1;
						state <= ST_IDLE;
					end
				end
				ST_PROGRAM: begin
					// pulse timed in flash clock ticks
					if (flash_operating_clock_tick) begin
						prog_cnt <= prog_cnt - 8'h01;
						if (prog_cnt == 8'h01) begin
							state <= ST_VERIFY_READ;
						end
					end
				end
				ST_VERIFY_READ: begin
					state <= ST_VERIFY_CHECK;
				end
				ST_VERIFY_CHECK: begin
					status.verify_err <= any_err;
					status.verify_fatal <= multi_err;
					status.done <= 1'b1;
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// block 0 read path
	// ------------------------------------------------------------
	// array contents are unstable while programming, so hide them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			block0_read_data <= INVALID_READ_DATA;
		end else begin
			block0_read_data <= next_busy ? INVALID_READ_DATA : block0_array_data;
		end
	end

endmodule

/* hw/otp_store.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// one-time field storage, one phrase per word
// ------------------------------------------------------------
module otp_store
	import flash_ctrl_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic wr_en,
	input wire logic [2:0] addr,
	input wire logic [63:0] wr_data,
	output logic [63:0] rd_data
);

	logic [63:0] mem [OTP_PHRASES]; // array, starts erased

	// write and registered read; reset restores the erased state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < OTP_PHRASES; i++) begin
				mem[i] <= ERASED_PHRASE;
			end
			rd_data <= ERASED_PHRASE;
		end else begin
			if (wr_en) begin
				mem[addr] <= wr_data;
			end
			rd_data <= mem[addr];
		end
	end

endmodule

/* verif/flash_array_model.sv */
`timescale 1ns/1ps
// ----
// flash array stand-in
// ----
module flash_array_model
	import flash_ctrl_pkg::*;
(
	input wire logic aclk,
	input wire logic [1:0] fire, // bit1 double, bit0 single fault
	input wire ecc_fault_t info_in,
	output logic ecc_single_fault,
	output logic ecc_double_fault,
	output ecc_fault_t ecc_fault_info,
	output logic [15:0] block0_array_data
);
	logic [15:0] walk = 16'h0; // read pattern, never sits still
	// one-cycle fault pulses; info is junk outside a pulse
	always_ff @(posedge aclk) begin
		walk <= walk + 16'h1357;
		ecc_single_fault <= fire[0];
		ecc_double_fault <= fire[1];
		ecc_fault_info <= (|fire) ? info_in : ~info_in;
	end
	assign block0_array_data = walk;
endmodule

/* verif/flash_otp_ctrl_props.sv */
`timescale 1ns/1ps
// ----
// port checks
// ----
module flash_otp_ctrl_props
	import flash_ctrl_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [15:0] block0_read_data,
	input wire logic flash_operating_clock,
	input wire logic busy
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	wire ar_go = s_axi_arvalid && s_axi_arready; // read address taken
	a_write_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
	a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
	a_read_answer: assert property (ar_go |=> s_axi_rvalid && !s_axi_arready) else $error("no read answer");
	a_write_ready_low: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready high");
	a_block0_invalid: assert property (busy && $past(busy) |-> block0_read_data == INVALID_READ_DATA)
		else $error("block 0 data leaked while busy");
	a_launch_busy: assert property ($rose(busy) |-> s_axi_bvalid) else $error("busy without launch");
	a_flash_operating_clock_strobe: assert property (flash_operating_clock |=> !flash_operating_clock) else $error("strobe");
	a_reserved_zero: assert property (ar_go && s_axi_araddr[7:0] == OFS_RESERVED_TEST |=> s_axi_rdata == 32'h0)
		else $error("test register not zero");
	a_unmapped_err: assert property (ar_go && s_axi_araddr[7:0] > OFS_PROTECT |=> s_axi_rresp == RESP_SLVERR)
		else $error("unmapped read not refused");
endmodule
bind flash_otp_ctrl flash_otp_ctrl_props props (.*);

/* verif/flash_program_once_command_control_tb_top.sv */
`timescale 1ns/1ps
module flash_program_once_command_control_tb_top;
	import flash_ctrl_pkg::*;
	// ----
	// stimulus and wiring
	// ----
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
	logic s_axi_bready = 1, s_axi_rready = 1; // always willing to take answers
	logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, rv;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] fire = 0, rr;
	ecc_fault_t info_in = '0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, busy, flash_operating_clock;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic ecc_single_fault, ecc_double_fault;
	ecc_fault_t ecc_fault_info;
	logic [15:0] block0_array_data, block0_read_data;
	int bad_count = 0, samples_checked = 0, cycles = 0;
	flash_otp_ctrl dut (.*);
	flash_array_model model (.*);
	initial forever #25 aclk = ~aclk;
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			test_done();
		end
	end
	task automatic test_done();
		$display("mismatches %0d checks %0d", bad_count, samples_checked);
		if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// ----
	// bus cycles
	// ----
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		rr = s_axi_bresp;
	endtask
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
	endtask
	task automatic launch(input logic [15:0] cmd, input logic [15:0] ph, input logic [31:0] last);
		for (int i = 0; i < 6; i++) begin
			wr(OFS_SLOT_INDEX, 32'(i));
			wr(OFS_COMMAND_OBJECT, i == 0 ? {16'h0, cmd} : i == 1 ? {16'h0, ph} : 32'h1111 * i);
		end
		wr(OFS_SLOT_INDEX, last);
		wr(OFS_STATUS, 32'h80);
	endtask
	// bounded wait for the sequencer to go idle
	task automatic wait_idle();
		int n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (busy !== 1'b0 && n < 500);
	endtask
	// launch, wait bounded for idle, judge status, clear error flags
	task automatic try(input logic [15:0] cmd, input logic [15:0] ph, input logic [31:0] last, input logic [31:0] e);
		launch(cmd, ph, last);
		wait_idle();
		rd(OFS_STATUS);
		chk(rv, e);
		wr(OFS_STATUS, 32'h30);
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_regs();
		rd(OFS_STATUS);
		chk(rv, 32'h80);
		wr(OFS_RESERVED_TEST, 32'hff);
		chk({30'h0, rr}, {30'h0, RESP_OKAY});
		rd(OFS_RESERVED_TEST);
		chk(rv, 32'h0);
		rd(8'h40);
		chk({rv[31:2], rr}, {30'h0, RESP_SLVERR});
	endtask
	task automatic t_refuse();
		int n = 0;
		try(16'h7, 16'h0, 32'h5, 32'ha0);
		wr(OFS_DIVIDER, 32'h2);
		wr(OFS_DIVIDER, 32'h30);
		rd(OFS_DIVIDER);
		chk(rv, 32'h82);
		repeat (30) begin
			@(posedge aclk);
			n += (flash_operating_clock === 1'b1);
		end
		chk(32'(n), 32'd10);
		try(16'h7, 16'h0, 32'h4, 32'ha0);
		try(16'h7, 16'h8, 32'h5, 32'ha0);
		try(16'h6, 16'h0, 32'h5, 32'ha0);
	endtask
	task automatic t_program();
		launch(16'h7, 16'h3, 32'h5);
		rd(OFS_STATUS);
		chk(rv, 32'h0);
		chk({16'h0, block0_read_data}, {16'h0, INVALID_READ_DATA});
		wait_idle();
		rd(OFS_STATUS);
		chk(rv, 32'h80);
		@(posedge aclk);
		rv = {16'h0, block0_array_data};
		@(posedge aclk);
		chk({16'h0, block0_read_data}, rv);
		try(16'h7, 16'h7, 32'h5, 32'h80);
		try(16'h7, 16'h3, 32'h5, 32'ha0);
		wr(OFS_PROTECT, 32'h1);
		try(16'h7, 16'h6, 32'h5, 32'h90);
	endtask
	task automatic fault(input logic [1:0] f, input logic [38:0] info);
		info_in <= info;
		fire <= f;
		@(posedge aclk);
		fire <= 2'b00;
		@(posedge aclk);
	endtask
	task automatic t_ecc();
		fault(2'b11, {23'h01_2345, 16'h5a5a});
		rd(OFS_ECC_FLAGS);
		chk(rv, 32'h2);
		wr(OFS_ECC_INDEX, 32'h1);
		rd(OFS_ECC_RESULT);
		chk(rv, 32'h2345);
		fault(2'b01, {23'h6_789a, 16'h1234});
		rd(OFS_ECC_RESULT);
		chk(rv, 32'h2345);
		wr(OFS_ECC_FLAGS, 32'h3);
		fault(2'b01, {23'h6_789a, 16'h1234});
		rd(OFS_ECC_FLAGS);
		chk(rv, 32'h1);
		wr(OFS_ECC_INDEX, 32'h2);
		rd(OFS_ECC_RESULT);
		chk(rv, 32'h1234);
		wr(OFS_ECC_INDEX, 32'h0);
		rd(OFS_ECC_RESULT);
		chk(rv, 32'h6);
	endtask
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_refuse();
		t_program();
		t_ecc();
		test_done();
	end
endmodule
